// >>> sar_adc_pkg.sv
// Shared constants and carrier types for the SAR converter sequencer
`default_nettype none
package sar_adc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_REF = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PIN = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_EOC = 2;
  localparam int CTRL_IRQ_EN = 3;
  localparam int CTRL_GIE = 4;
  localparam int CTRL_FLAG = 5;
  localparam int CTRL_CLKDIV = 6;
  localparam int CTRL_SAMPLE = 8;
  localparam int CTRL_RES = 10;
  // Reference and channel register fields
  localparam int REF_EXT = 0;
  localparam int REF_LEVEL = 1;
  localparam int REF_GATE = 3;
  localparam int REF_CHAN = 4;
  localparam int PIN_COUNT = 11;
  localparam int SRC_COUNT = 12;
  localparam int RESULT_W = 12;
  // Reset values
  localparam logic [1:0] CLKDIV_RESET = 2'h0;
  localparam logic [1:0] SAMPLE_RESET = 2'h0;
  localparam logic [1:0] RES_RESET = 2'h0;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 11'h000;
  // Converter clock division minus one per clock field code
  localparam logic [3:0] DIV_LIMIT_00 = 4'hf;
  localparam logic [3:0] DIV_LIMIT_01 = 4'h7;
  localparam logic [3:0] DIV_LIMIT_10 = 4'h0;
  localparam logic [3:0] DIV_LIMIT_11 = 4'h1;
  // Sampling length minus one per sampling field code
  localparam logic [3:0] SAMPLE_LAST_00 = 4'h0;
  localparam logic [3:0] SAMPLE_LAST_01 = 4'h1;
  localparam logic [3:0] SAMPLE_LAST_10 = 4'h3;
  localparam logic [3:0] SAMPLE_LAST_11 = 4'h7;
  // Lowest decided bit per resolution
  localparam logic [3:0] LSB_8BIT = 4'h4;
  localparam logic [3:0] LSB_10BIT = 4'h2;
  localparam logic [3:0] LSB_12BIT = 4'h0;
  localparam logic [3:0] MSB_INDEX = 4'hb;
  localparam logic [3:0] QUARTER_SUPPLY = 4'hb;
  // Bias settle wait that firmware keeps after enabling
  localparam int BIAS_SETTLE_US = 256;

  typedef struct packed {
    logic [1:0] clk_div;
    logic [1:0] sample_sel;
    logic [1:0] res_sel;
  } conv_cfg_s;
endpackage
`default_nettype wire

// >>> conv_clock_gen.sv
// Converter clock divider: tick enable and observable clock level
`default_nettype none
`timescale 1ns/1ps
module conv_clock_gen
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic [1:0] clk_div,
  output logic tick,
  output logic conv_clock
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic [3:0] limit;
  logic next_conv_clock;

  always_comb
  begin
    unique case (clk_div)
      2'b00: limit = sar_adc_pkg::DIV_LIMIT_00;
      2'b01: limit = sar_adc_pkg::DIV_LIMIT_01;
      2'b10: limit = sar_adc_pkg::DIV_LIMIT_10;
      2'b11: limit = sar_adc_pkg::DIV_LIMIT_11;
    endcase
    tick = !restart && (count == limit);
    if (restart || tick)
      next_count = 4'h0;
    else
      next_count = count + 4'h1;
    // High in the first cycle of each period; steady high at divide by one
    next_conv_clock = (next_count == 4'h0);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 4'h0;
      conv_clock <= 1'b0;
    end
    else
    begin
      count <= next_count;
      conv_clock <= next_conv_clock;
    end
  end
endmodule
`default_nettype wire

// >>> sar_core.sv
// Successive approximation sequencer stepping on converter clock ticks
`default_nettype none
`timescale 1ns/1ps
module sar_core
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic abort,
  input wire logic tick,
  input wire sar_adc_pkg::conv_cfg_s cfg,
  input wire logic comp_high,
  output logic busy,
  output logic done,
  output logic [11:0] result,
  output logic [11:0] dac_code,
  output logic sample_window
);
  typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_SETTLE, S_BITS, S_FINISH}
    state_e;
  state_e state;
  state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [11:0] next_result;
  logic [11:0] next_dac_code;
  logic next_sample_window;
  logic next_done;
  logic [3:0] lsb;
  logic [3:0] sample_last;
  logic [11:0] trial_bit;
  logic [11:0] decided;

  always_comb
  begin
    unique case (cfg.res_sel)
      2'b00: lsb = sar_adc_pkg::LSB_8BIT;
      2'b01: lsb = sar_adc_pkg::LSB_10BIT;
      default: lsb = sar_adc_pkg::LSB_12BIT;
    endcase
    unique case (cfg.sample_sel)
      2'b00: sample_last = sar_adc_pkg::SAMPLE_LAST_00;
      2'b01: sample_last = sar_adc_pkg::SAMPLE_LAST_01;
      2'b10: sample_last = sar_adc_pkg::SAMPLE_LAST_10;
      2'b11: sample_last = sar_adc_pkg::SAMPLE_LAST_11;
    endcase
    trial_bit = 12'h001 << bit_idx;
    // Keep the trial bit only when the input sits above the DAC level
    decided = comp_high ? dac_code : (dac_code & ~trial_bit);
    next_state = state;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_result = result;
    next_dac_code = dac_code;
    next_sample_window = sample_window;
    next_done = 1'b0;
    if (abort)
    begin
      next_state = S_IDLE;
      next_sample_window = 1'b0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (go)
          begin
            next_state = S_SAMPLE;
            next_cnt = sample_last;
            next_result = 12'h000;
            next_dac_code = 12'h000;
            next_sample_window = 1'b1;
          end
        S_SAMPLE:
          if (tick)
          begin
            if (cnt == 4'h0)
            begin
              next_state = S_SETTLE;
              next_sample_window = 1'b0;
            end
            else
              next_cnt = cnt - 4'h1;
          end
        S_SETTLE:
          if (tick)
          begin
            next_state = S_BITS;
            next_bit_idx = sar_adc_pkg::MSB_INDEX;
            next_dac_code = 12'h800;
          end
        S_BITS:
          if (tick)
          begin
            next_result = decided;
            if (bit_idx == lsb)
            begin
              // Unused low bits never get a trial bit, so read as zero
              next_state = S_FINISH;
              next_dac_code = decided;
            end
            else
            begin
              next_bit_idx = bit_idx - 4'h1;
              next_dac_code = decided | (trial_bit >> 1);
            end
          end
        S_FINISH:
          if (tick)
          begin
            next_state = S_IDLE;
            next_done = 1'b1;
          end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= S_IDLE;
      cnt <= 4'h0;
      bit_idx <= 4'h0;
      result <= 12'h000;
      dac_code <= 12'h000;
      sample_window <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      result <= next_result;
      dac_code <= next_dac_code;
      sample_window <= next_sample_window;
      done <= next_done;
    end
  end

  assign busy = (state != S_IDLE);
endmodule
`default_nettype wire

// >>> sar_adc_sequencer.sv
// SAR converter sequencer with AXI4-Lite register slave
`default_nettype none
`timescale 1ns/1ps
module sar_adc_sequencer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comp_high,
  output logic [11:0] dac_code,
  output logic sample_window,
  output logic conv_clock,
  output logic [4:0] high_ref_control,
  output logic [11:0] channel_connect,
  output logic [10:0] pin_analog_config,
  output logic conv_irq
);
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic conv_enable;
  logic start_bit;
  logic eoc;
  logic conv_irq_enable;
  logic global_irq_enable;
  logic conv_irq_flag;
  sar_adc_pkg::conv_cfg_s cfg;
  logic ext_ref_select;
  logic [1:0] int_ref_level;
  logic global_channel_gate;
  logic [3:0] input_channel_sel;

  logic next_aw_held;
  logic [7:0] next_aw_addr;
  logic next_w_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_conv_enable;
  logic next_start_bit;
  logic next_eoc;
  logic next_conv_irq_enable;
  logic next_global_irq_enable;
  logic next_conv_irq_flag;
  sar_adc_pkg::conv_cfg_s next_cfg;
  logic next_ext_ref_select;
  logic [1:0] next_int_ref_level;
  logic next_global_channel_gate;
  logic [3:0] next_input_channel_sel;
  logic [10:0] next_pin_analog_config;
  logic [4:0] next_high_ref_control;
  logic [11:0] next_channel_connect;
  logic next_conv_irq;

  logic do_write;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [31:0] ref_word;
  logic [31:0] pin_word;
  logic [31:0] ctrl_new;
  logic [31:0] ref_new;
  logic [31:0] pin_new;
  logic go;
  logic tick;
  logic core_busy;
  logic core_done;
  logic [11:0] core_result;

  conv_clock_gen u_clk
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(go),
    .clk_div(cfg.clk_div),
    .tick(tick),
    .conv_clock(conv_clock)
  );

  sar_core u_core
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .go(go),
    .abort(!conv_enable),
    .tick(tick),
    .cfg(cfg),
    .comp_high(comp_high),
    .busy(core_busy),
    .done(core_done),
    .result(core_result),
    .dac_code(dac_code),
    .sample_window(sample_window)
  );

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[sar_adc_pkg::CTRL_ENABLE] = conv_enable;
    ctrl_word[sar_adc_pkg::CTRL_START] = start_bit;
    ctrl_word[sar_adc_pkg::CTRL_EOC] = eoc;
    ctrl_word[sar_adc_pkg::CTRL_IRQ_EN] = conv_irq_enable;
    ctrl_word[sar_adc_pkg::CTRL_GIE] = global_irq_enable;
    ctrl_word[sar_adc_pkg::CTRL_FLAG] = conv_irq_flag;
    ctrl_word[sar_adc_pkg::CTRL_CLKDIV +: 2] = cfg.clk_div;
    ctrl_word[sar_adc_pkg::CTRL_SAMPLE +: 2] = cfg.sample_sel;
    ctrl_word[sar_adc_pkg::CTRL_RES +: 2] = cfg.res_sel;
    ref_word = 32'h0000_0000;
    ref_word[sar_adc_pkg::REF_EXT] = ext_ref_select;
    ref_word[sar_adc_pkg::REF_LEVEL +: 2] = int_ref_level;
    ref_word[sar_adc_pkg::REF_GATE] = global_channel_gate;
    ref_word[sar_adc_pkg::REF_CHAN +: 4] = input_channel_sel;
    pin_word = {21'h000000, pin_analog_config};

    // Either channel may arrive first; hold each until both are present
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    do_write = aw_held && w_held && !s_axi_bvalid;
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    ctrl_new = (ctrl_word & ~wmask) | (w_data & wmask);
    ref_new = (ref_word & ~wmask) | (w_data & wmask);
    pin_new = (pin_word & ~wmask) | (w_data & wmask);

    next_conv_enable = conv_enable;
    next_start_bit = start_bit;
    next_eoc = eoc;
    next_conv_irq_enable = conv_irq_enable;
    next_global_irq_enable = global_irq_enable;
    next_conv_irq_flag = conv_irq_flag;
    next_cfg = cfg;
    next_ext_ref_select = ext_ref_select;
    next_int_ref_level = int_ref_level;
    next_global_channel_gate = global_channel_gate;
    next_input_channel_sel = input_channel_sel;
    next_pin_analog_config = pin_analog_config;
    go = 1'b0;

    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = sar_adc_pkg::RESP_OKAY;
      unique case (aw_addr)
        sar_adc_pkg::ADDR_CTRL:
        begin
          next_conv_enable = ctrl_new[sar_adc_pkg::CTRL_ENABLE];
          next_conv_irq_enable = ctrl_new[sar_adc_pkg::CTRL_IRQ_EN];
          next_global_irq_enable = ctrl_new[sar_adc_pkg::CTRL_GIE];
          next_cfg.clk_div = ctrl_new[sar_adc_pkg::CTRL_CLKDIV +: 2];
          next_cfg.sample_sel = ctrl_new[sar_adc_pkg::CTRL_SAMPLE +: 2];
          next_cfg.res_sel = ctrl_new[sar_adc_pkg::CTRL_RES +: 2];
          // Writing 1 to the flag does nothing; only 0 clears it
          if (w_strb[0] && !w_data[sar_adc_pkg::CTRL_FLAG])
            next_conv_irq_flag = 1'b0;
          // Stale start while idle-disabled or busy is dropped
          if (w_strb[0] && w_data[sar_adc_pkg::CTRL_START] && conv_enable
              && !start_bit && !core_busy)
          begin
            go = 1'b1;
            next_start_bit = 1'b1;
            next_eoc = 1'b0;
          end
        end
        sar_adc_pkg::ADDR_REF:
        begin
          next_ext_ref_select = ref_new[sar_adc_pkg::REF_EXT];
          next_int_ref_level = ref_new[sar_adc_pkg::REF_LEVEL +: 2];
          next_global_channel_gate = ref_new[sar_adc_pkg::REF_GATE];
          next_input_channel_sel = ref_new[sar_adc_pkg::REF_CHAN +: 4];
        end
        sar_adc_pkg::ADDR_PIN:
          next_pin_analog_config = pin_new[10:0];
        sar_adc_pkg::ADDR_RESULT:
          next_bresp = sar_adc_pkg::RESP_OKAY;
        default:
          next_bresp = sar_adc_pkg::RESP_SLVERR;
      endcase
    end

    // Completion sets after any clear in the same cycle, so it wins
    if (core_done)
    begin
      next_start_bit = 1'b0;
      next_eoc = 1'b1;
      next_conv_irq_flag = 1'b1;
    end
    if (!conv_enable)
      next_start_bit = 1'b0;

    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;

    // Free for a new address whenever no read data is waiting
    next_arready = !s_axi_rvalid;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = sar_adc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sar_adc_pkg::ADDR_CTRL: next_rdata = ctrl_word;
        sar_adc_pkg::ADDR_REF: next_rdata = ref_word;
        sar_adc_pkg::ADDR_PIN: next_rdata = pin_word;
        sar_adc_pkg::ADDR_RESULT: next_rdata = {20'h00000, core_result};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = sar_adc_pkg::RESP_SLVERR;
        end
      endcase
    end

    next_high_ref_control = 5'h00;
    if (next_ext_ref_select)
      next_high_ref_control[4] = 1'b1;
    else
      next_high_ref_control[next_int_ref_level] = 1'b1;
    next_channel_connect = 12'h000;
    if (next_global_channel_gate &&
        next_input_channel_sel <= sar_adc_pkg::QUARTER_SUPPLY)
      next_channel_connect[next_input_channel_sel] = 1'b1;
    next_conv_irq = next_conv_irq_flag && next_conv_irq_enable
                    && next_global_irq_enable;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      conv_enable <= 1'b0;
      start_bit <= 1'b0;
      eoc <= 1'b0;
      conv_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
      conv_irq_flag <= 1'b0;
      cfg <= '{sar_adc_pkg::CLKDIV_RESET, sar_adc_pkg::SAMPLE_RESET,
               sar_adc_pkg::RES_RESET};
      ext_ref_select <= 1'b0;
      int_ref_level <= sar_adc_pkg::LEVEL_RESET;
      global_channel_gate <= 1'b0;
      input_channel_sel <= sar_adc_pkg::CHAN_RESET;
      pin_analog_config <= sar_adc_pkg::PIN_RESET;
      high_ref_control <= 5'h00;
      channel_connect <= 12'h000;
      conv_irq <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      conv_enable <= next_conv_enable;
      start_bit <= next_start_bit;
      eoc <= next_eoc;
      conv_irq_enable <= next_conv_irq_enable;
      global_irq_enable <= next_global_irq_enable;
      conv_irq_flag <= next_conv_irq_flag;
      cfg <= next_cfg;
      ext_ref_select <= next_ext_ref_select;
      int_ref_level <= next_int_ref_level;
      global_channel_gate <= next_global_channel_gate;
      input_channel_sel <= next_input_channel_sel;
      pin_analog_config <= next_pin_analog_config;
      high_ref_control <= next_high_ref_control;
      channel_connect <= next_channel_connect;
      conv_irq <= next_conv_irq;
    end
  end
endmodule
`default_nettype wire

// >>> analog_source_model.sv
// Analog input model: comparator against the trial code
`timescale 1ns/1ps
`default_nettype none
module analog_source_model
(
  input wire logic [12:0] vin_half,
  input wire logic [11:0] dac_code,
  output logic comp_high
);
  // Input held in half steps so it never equals a trial level
  assign comp_high = vin_half > {dac_code, 1'b0};
endmodule
`default_nettype wire

// >>> sar_adc_sequencer_chk.sv
// Port-level assertions for the SAR sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] dac_code,
  input wire logic sample_window,
  input wire logic [4:0] high_ref_control,
  input wire logic [11:0] channel_connect,
  input wire logic conv_irq
);
  logic [7:0] sw_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Longest window is eight ticks at divide by 16
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sample_window)
      sw_cnt <= 8'h00;
    else
      sw_cnt <= sw_cnt + 8'h01;
  end
  ref_onehot_a: assert property ($onehot0(high_ref_control))
    else $error("reference select not one-hot");
  chan_onehot_a: assert property ($onehot0(channel_connect))
    else $error("more than one input connected");
  sample_len_a: assert property (sw_cnt <= 8'h81)
    else $error("sampling window too long");
  msb_trial_a: assert property (
    $fell(sample_window) |-> ##[0:40] dac_code == 12'h800)
    else $error("no top bit trial after sampling");
  // A write lands on the same edge that raises its response
  irq_hold_a: assert property (
    $fell(conv_irq) |-> s_axi_bvalid)
    else $error("interrupt dropped without a write");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data withdrawn");
  cover property ($rose(conv_irq));
  cover property ($fell(sample_window));
  cover property (channel_connect[11]);
endmodule
bind sar_adc_sequencer sar_adc_sequencer_chk chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .dac_code(dac_code),
  .sample_window(sample_window), .high_ref_control(high_ref_control),
  .channel_connect(channel_connect), .conv_irq(conv_irq));
`default_nettype wire

// >>> sar_adc_sequencer_tb_top.sv
// Register-level tests of the SAR sequencer over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  err_count++; $display("Error %s expected %h seen %h", nm, exp, got); \
  end end
module sar_adc_sequencer_tb_top;
  logic aclk, aresetn, comp_high, sample_window, conv_clock, conv_irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_v, cfg;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_v;
  logic [11:0] dac_code, channel_connect;
  logic [4:0] high_ref_control;
  logic [10:0] pin_analog_config;
  logic [12:0] vin_half;
  int err_count = 0, compares = 0, cyc = 0, t0, lo, clk_hi = 0;
  int divs[4] = '{16, 8, 1, 2};
  int samp[4] = '{1, 2, 4, 8};
  int bits[4] = '{8, 10, 12, 12};
  logic [11:0] masks[4] = '{12'hff0, 12'hffc, 12'hfff, 12'hfff};
  sar_adc_sequencer uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .comp_high(comp_high),
    .dac_code(dac_code), .sample_window(sample_window),
    .conv_clock(conv_clock), .high_ref_control(high_ref_control),
    .channel_connect(channel_connect),
    .pin_analog_config(pin_analog_config), .conv_irq(conv_irq));
  analog_source_model analog (.vin_half(vin_half), .dac_code(dac_code),
    .comp_high(comp_high));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  always @(posedge aclk) clk_hi <= clk_hi + int'(conv_clock);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_ok)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp_v = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdata_v = s_axi_rdata;
    resp_v = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bias wait alone is 25600 cycles
  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    vin_half = {12'h9c7, 1'b1};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'(i * 4));
      `CHK("reset_value", 32'h0, rdata_v)
      `CHK("read_resp", i == 4 ? sar_adc_pkg::RESP_SLVERR : 2'h0, resp_v)
    end
    $display("register reset test done");
    for (int i = 0; i < 17; i++)
    begin
      cfg = (i << sar_adc_pkg::REF_CHAN) | ((i % 4) << sar_adc_pkg::REF_LEVEL);
      wr(sar_adc_pkg::ADDR_REF, i == 16 ? 32'h1 : cfg | 32'h8);
      @(posedge aclk);
      `CHK("ref", i == 16 ? 5'h10 : 5'h1 << (i % 4), high_ref_control)
      `CHK("chan", i < 12 ? 12'h1 << i : 12'h0, channel_connect)
    end
    $display("reference and channel test done");
    wr(sar_adc_pkg::ADDR_PIN, 32'h5a5);
    @(posedge aclk);
    `CHK("pin_cfg", 11'h5a5, pin_analog_config)
    wr(sar_adc_pkg::ADDR_CTRL, 32'h2);
    rd(sar_adc_pkg::ADDR_CTRL);
    `CHK("start_off", 1'b0, rdata_v[sar_adc_pkg::CTRL_START])
    $display("pin and start gating test done");
    wr(sar_adc_pkg::ADDR_REF, 32'h8);
    for (int i = 0; i < 4; i++)
    begin
      cfg = (i << sar_adc_pkg::CTRL_CLKDIV) | (i << sar_adc_pkg::CTRL_SAMPLE);
      cfg = cfg | (i << sar_adc_pkg::CTRL_RES) | ((i % 2) * 32'h18);
      // Stay enabled after the first pass; re-enabling needs the bias wait
      wr(sar_adc_pkg::ADDR_CTRL, i == 0 ? cfg : cfg | 32'h1);
      wr(sar_adc_pkg::ADDR_CTRL, cfg | 32'h1);
      if (i == 0) repeat (25600) @(posedge aclk);
      wr(sar_adc_pkg::ADDR_CTRL, cfg | 32'h3);
      t0 = cyc;
      rd(sar_adc_pkg::ADDR_CTRL);
      `CHK("busy", 2'b01, rdata_v[2:1])
      for (int k = 0; k < 200 && rdata_v[2] !== 1'b1; k++)
        rd(sar_adc_pkg::ADDR_CTRL);
      lo = divs[i] * (samp[i] + bits[i] + 2);
      `CHK("conv_time", 1'b1, (cyc - t0 >= lo && cyc - t0 <= lo + 12))
      `CHK("done", 2'b10, rdata_v[2:1])
      `CHK("flag", 1'b1, rdata_v[sar_adc_pkg::CTRL_FLAG])
      `CHK("irq", i % 2 == 1, conv_irq)
      rd(sar_adc_pkg::ADDR_RESULT);
      `CHK("result", {20'h0, 12'h9c7 & masks[i]}, rdata_v)
      wr(sar_adc_pkg::ADDR_CTRL, cfg | 32'h1);
      repeat (2) @(posedge aclk);
      `CHK("irq_clear", 1'b0, conv_irq)
      lo = clk_hi;
      repeat (32) @(posedge aclk);
      `CHK("conv_clock", 32 / divs[i], clk_hi - lo)
    end
    $display("conversion test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
